// [odsb_pkg.sv]
// Constants and types for the output diagnostic status bank.
// Assumes a 40 MHz core clock and a host that reaches the two status
// words through the access port of the bank.
//
// Contract
// - Every output stage has its own underload flag, eighteen in all.
// - Underload is watched only while the stage is switched on.
// - Underload sets only after current stays low for the filter time.
// - Any unmasked underload flag sets the global underload bit.
// - Bridge one masks keep its high and low stages off the global bit.
// - The all-outputs mask keeps every underload off the global bit.
// - Lamp overcurrent sets its flag and stops that output.
// - Any overcurrent also sets the global fault summary.
// - With recovery on, a tripped output returns after the retry delay.
// - Undervoltage disables all stages at once and sets its flag.
// - Overvoltage disables all stages at once and sets its flag.
// - With latch mode clear, outputs return once supply is valid again.
// - Two comparators track mirror feedback against target in mirror mode.
// - Mirror bits: 00 in range, above bit high, below bit high, 11 unused.
// - Mirror deviation shows after 32 us and changes no sooner than 32 us.
// - Mirror bits follow the live comparators and are not latched.
// - Mirror bits never feed the global fault summary.

package odsb_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] ADDR_STATUS_1 = 6'h11;
	localparam logic [5:0] ADDR_STATUS_2 = 6'h12;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;

	// Field positions: flags fill from bit 15 downward, in lamp pairs in status 2
	localparam int ST1_FIRST_BIT = 15;
	localparam int ST2_FIRST_BIT = 15;
	localparam int ST2_VSUV = 3;
	localparam int ST2_VSOV = 2;
	localparam int ST2_BELOW = 1;
	localparam int ST2_ABOVE = 0;

	// ------------------------------------------------------------
	// Stage counts
	// ------------------------------------------------------------
	localparam int N_BRIDGE = 12;
	localparam int N_LAMP = 6;
	localparam int N_OUT = N_BRIDGE + N_LAMP;
	localparam int RETRY_W = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int EC_FILTER_US = 32;
	localparam int EC_FILTER_CYC = EC_FILTER_US * CLK_MHZ;
	localparam int EC_W = $clog2(EC_FILTER_CYC + 1);
	localparam int ULD_FILTER_US_DEF = 200;
	localparam int RETRY_UNIT_US_DEF = 1000;

	// Host access request, one per cycle while valid
	typedef struct packed {
		logic valid;
		logic clear;
		logic [ADDR_W-1:0] addr;
	} odsb_acc_t;

	typedef struct packed {
		logic below;
		logic above;
	} odsb_ec_t;

endpackage : odsb_pkg

// [odsb_output_diag_status_bank.sv]
// Diagnostic status bank: underload, overcurrent, supply and mirror flags.
// Comparator inputs arrive from the analog side, asynchronous to core_clk.
// Output commands come from the host control logic on core_clk.

`timescale 1ns/100ps

module odsb_output_diag_status_bank #(
	parameter int ULD_FILTER_US = odsb_pkg::ULD_FILTER_US_DEF,
	parameter int RETRY_UNIT_US = odsb_pkg::RETRY_UNIT_US_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Host status access
	input odsb_pkg::odsb_acc_t acc,
	output logic acc_ack,
	output logic [15:0] acc_rdata,
	// Control from the host side
	input wire logic [odsb_pkg::N_OUT-1:0] output_on,
	input wire logic overcurrent_recovery_enable,
	input wire logic [odsb_pkg::RETRY_W-1:0] overcurrent_retry_delay,
	input wire logic supply_fault_latch_mode,
	input wire logic mask_underload_bridge1_high,
	input wire logic mask_underload_bridge1_low,
	input wire logic mask_underload_all_outputs,
	input wire logic electrochromic_mirror_mode,
	// Analog comparators
	input wire logic [odsb_pkg::N_OUT-1:0] undercurrent_raw,
	input wire logic [odsb_pkg::N_LAMP-1:0] overcurrent_raw,
	input wire logic undervoltage_raw,
	input wire logic overvoltage_raw,
	input wire logic mirror_above_raw,
	input wire logic mirror_below_raw,
	// Results
	output logic [odsb_pkg::N_OUT-1:0] stage_enable,
	output logic global_underload,
	output logic global_fault_summary,
	output logic mirror_above_target,
	output logic mirror_below_target
);
	import odsb_pkg::*;

	localparam int ULD_CYC = ULD_FILTER_US * CLK_MHZ;
	localparam int ULD_W = $clog2(ULD_CYC + 1);
	localparam int RETRY_CYC = RETRY_UNIT_US * CLK_MHZ;
	localparam int RT_W = $clog2((2 ** RETRY_W) * RETRY_CYC + 1);
	localparam int PIN_W = N_OUT + N_LAMP + 4;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// A bit moves only when stages two and three agree, so one
	// metastable sample can never flip a filtered level.
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_q;
	wire [PIN_W-1:0] pin_raw = {undercurrent_raw, overcurrent_raw,
		undervoltage_raw, overvoltage_raw, mirror_above_raw, mirror_below_raw};
	wire [PIN_W-1:0] pin_agree = ~(pin_s2 ^ pin_s3);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_q <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_q <= (pin_s2 & pin_agree) | (pin_q & ~pin_agree);
		end
	end

	wire [N_OUT-1:0] uc_q = pin_q[PIN_W-1 -: N_OUT];
	wire [N_LAMP-1:0] oc_q = pin_q[N_LAMP+3:4];
	wire uv_q = pin_q[3];
	wire ov_q = pin_q[2];
	wire above_q = pin_q[1];
	wire below_q = pin_q[0];

	// ------------------------------------------------------------
	// Flag state and clear decode
	// ------------------------------------------------------------
	logic [N_OUT-1:0] uld_flag;
	logic [N_LAMP-1:0] oc_flag;
	logic [N_LAMP-1:0] oc_off;
	logic uv_flag;
	logic ov_flag;
	odsb_ec_t ec_state;
	wire [N_OUT-1:0] uld_hit;

	wire clr1 = acc.valid && acc.clear && acc.addr == ADDR_STATUS_1;
	wire clr2 = acc.valid && acc.clear && acc.addr == ADDR_STATUS_2;
	wire [N_OUT-1:0] uld_keep = ~{{N_LAMP{clr2}}, {N_BRIDGE{clr1}}};
	wire [N_LAMP-1:0] oc_event = oc_q & stage_enable[N_OUT-1:N_BRIDGE];

	// Set wins over a clear in the same cycle
	wire [N_OUT-1:0] next_uld_flag = uld_hit | (uld_flag & uld_keep);
	wire [N_LAMP-1:0] next_oc_flag = oc_event | (oc_flag & ~{N_LAMP{clr2}});
	wire next_uv_flag = uv_q | (uv_flag & ~clr2);
	wire next_ov_flag = ov_q | (ov_flag & ~clr2);

	// ------------------------------------------------------------
	// Underload filters
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_OUT; gi++) begin : g_uld
			logic [ULD_W-1:0] low_cnt;
			wire low_on = stage_enable[gi] && uc_q[gi];
			// The count restarts on any gap in the low current
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					low_cnt <= '0;
				end else if (!low_on) begin
					low_cnt <= '0;
				end else if (low_cnt != ULD_W'(ULD_CYC)) begin
					low_cnt <= low_cnt + 1'b1;
				end
			end
			assign uld_hit[gi] = low_on && low_cnt == ULD_W'(ULD_CYC);
		end
	endgenerate

	// ------------------------------------------------------------
	// Overcurrent shutdown and retry
	// ------------------------------------------------------------
	wire [RT_W-1:0] retry_limit =
		RT_W'((32'(overcurrent_retry_delay) + 32'd1) * RETRY_CYC);

	generate
		for (gi = 0; gi < N_LAMP; gi++) begin : g_oc
			logic [RT_W-1:0] wait_cnt;
			wire host_release = !oc_flag[gi] && !output_on[N_BRIDGE+gi];
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					oc_off[gi] <= 1'b0;
					wait_cnt <= '0;
				end else if (oc_event[gi]) begin
					oc_off[gi] <= 1'b1;
					wait_cnt <= '0;
				end else if (oc_off[gi] && overcurrent_recovery_enable) begin
					if (wait_cnt >= retry_limit) begin
						oc_off[gi] <= 1'b0;
					end else begin
						wait_cnt <= wait_cnt + 1'b1;
					end
				end else if (oc_off[gi] && host_release) begin
					// Host must drop the command too, so no surprise restart
					oc_off[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Supply fault gating and stage enables
	// ------------------------------------------------------------
	wire supply_live = uv_q || ov_q;
	// Latched mode holds off until the host clears the flag
	wire supply_held = supply_fault_latch_mode && (uv_flag || ov_flag);
	wire supply_block = supply_live || supply_held;
	wire [N_OUT-1:0] oc_block = {oc_off | oc_event, {N_BRIDGE{1'b0}}};
	wire [N_OUT-1:0] next_stage_enable =
		output_on & ~oc_block & ~{N_OUT{supply_block}};

	// ------------------------------------------------------------
	// Global summaries
	// ------------------------------------------------------------
	wire [N_OUT-1:0] uld_gate = {{(N_OUT-2){1'b1}},
		~mask_underload_bridge1_low, ~mask_underload_bridge1_high};
	wire next_global_underload = !mask_underload_all_outputs &&
		|(next_uld_flag & uld_gate);
	// Mirror status stays out of the summary on purpose
	wire next_global_fault = |next_oc_flag || next_uv_flag || next_ov_flag;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			uld_flag <= '0;
			oc_flag <= '0;
			uv_flag <= 1'b0;
			ov_flag <= 1'b0;
			stage_enable <= '0;
			global_underload <= 1'b0;
			global_fault_summary <= 1'b0;
		end else begin
			uld_flag <= next_uld_flag;
			oc_flag <= next_oc_flag;
			uv_flag <= next_uv_flag;
			ov_flag <= next_ov_flag;
			stage_enable <= next_stage_enable;
			global_underload <= next_global_underload;
			global_fault_summary <= next_global_fault;
		end
	end

	// ------------------------------------------------------------
	// Mirror regulation status
	// ------------------------------------------------------------
	// The unused code reads as in range so it can never be reported
	odsb_ec_t ec_cand;
	odsb_ec_t ec_seen;
	logic [EC_W-1:0] ec_settle;
	logic [EC_W-1:0] ec_hold;
	wire ec_both = above_q && below_q;
	wire ec_live = electrochromic_mirror_mode && !ec_both;
	assign ec_cand = '{below: below_q && ec_live, above: above_q && ec_live};
	wire ec_new = ec_cand != ec_seen;
	wire ec_change = !ec_new && ec_seen != ec_state &&
		ec_settle == EC_W'(EC_FILTER_CYC) &&
		ec_hold == EC_W'(EC_FILTER_CYC);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ec_seen <= '0;
			ec_settle <= '0;
			ec_hold <= '0;
			ec_state <= '0;
		end else begin
			ec_seen <= ec_cand;
			if (ec_new) begin
				ec_settle <= '0;
			end else if (ec_settle != EC_W'(EC_FILTER_CYC)) begin
				ec_settle <= ec_settle + 1'b1;
			end
			if (ec_change) begin
				ec_hold <= '0;
				ec_state <= ec_seen;
			end else if (ec_hold != EC_W'(EC_FILTER_CYC)) begin
				ec_hold <= ec_hold + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Status words and host read
	// ------------------------------------------------------------
	logic [15:0] status_1;
	logic [15:0] status_2;
	generate
		for (gi = 0; gi < N_BRIDGE; gi++) begin : g_st1
			assign status_1[ST1_FIRST_BIT-gi] = uld_flag[gi];
		end
		for (gi = 0; gi < N_LAMP; gi++) begin : g_st2
			assign status_2[ST2_FIRST_BIT-2*gi] = oc_flag[gi];
			assign status_2[ST2_FIRST_BIT-2*gi-1] = uld_flag[N_BRIDGE+gi];
		end
	endgenerate
	assign status_1[3:0] = 4'h0;
	assign status_2[ST2_VSUV] = uv_flag;
	assign status_2[ST2_VSOV] = ov_flag;
	assign status_2[ST2_BELOW] = ec_state.below;
	assign status_2[ST2_ABOVE] = ec_state.above;

	// Read returns the value before any clear in the same access
	wire [15:0] next_rdata = (acc.addr == ADDR_STATUS_1) ? status_1 :
		(acc.addr == ADDR_STATUS_2) ? status_2 : READ_UNMAPPED;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			acc_ack <= 1'b0;
			acc_rdata <= RST_STATUS;
			mirror_above_target <= 1'b0;
			mirror_below_target <= 1'b0;
		end else begin
			acc_ack <= acc.valid;
			if (acc.valid) begin
				acc_rdata <= next_rdata;
			end
			mirror_above_target <= ec_state.above;
			mirror_below_target <= ec_state.below;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [31:0] low_run0;
	logic [31:0] ec_age;
	always_ff @(posedge core_clk) begin
		if (!nrst || !(stage_enable[0] && uc_q[0])) begin
			low_run0 <= '0;
		end else begin
			low_run0 <= low_run0 + 32'd1;
		end
		if (!nrst || $changed(ec_state)) begin
			ec_age <= '0;
		end else begin
			ec_age <= ec_age + 32'd1;
		end
	end

	property p_uld_only_on;
		@(posedge core_clk) disable iff (!nrst)
		(uld_flag & ~$past(uld_flag) & ~$past(stage_enable)) == '0;
	endproperty
	a_uld_only_on: assert property (p_uld_only_on) else $error("underload set while off");

	property p_uld_filter;
		@(posedge core_clk) disable iff (!nrst)
		$rose(uld_flag[0]) |-> $past(low_run0) >= 32'(ULD_CYC);
	endproperty
	a_uld_filter: assert property (p_uld_filter) else $error("underload set too early");

	property p_global_uld;
		@(posedge core_clk) disable iff (!nrst)
		(!$past(mask_underload_all_outputs) && |(uld_flag & $past(uld_gate)))
			|-> global_underload;
	endproperty
	a_global_uld: assert property (p_global_uld) else $error("global underload missing");
	property p_mask_bridge1;
		@(posedge core_clk) disable iff (!nrst)
		($past(mask_underload_bridge1_high) || !uld_flag[0]) &&
			($past(mask_underload_bridge1_low) || !uld_flag[1]) &&
			uld_flag[N_OUT-1:2] == '0 |-> !global_underload;
	endproperty
	a_mask_bridge1: assert property (p_mask_bridge1) else $error("bridge one mask ignored");

	property p_mask_all;
		@(posedge core_clk) disable iff (!nrst)
		$past(mask_underload_all_outputs) |-> !global_underload;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("all-output mask ignored");
	property p_oc_trip;
		@(posedge core_clk) disable iff (!nrst)
		(oc_event != '0) |=> ((oc_flag & $past(oc_event)) == $past(oc_event))
			&& ((stage_enable[N_OUT-1:N_BRIDGE] & $past(oc_event)) == '0)
			&& global_fault_summary;
	endproperty
	a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not handled");

	property p_supply_off;
		@(posedge core_clk) disable iff (!nrst)
		(uv_q || ov_q) |=> stage_enable == '0 && (uv_flag || ov_flag);
	endproperty
	a_supply_off: assert property (p_supply_off) else $error("supply fault not handled");

	property p_supply_return;
		@(posedge core_clk) disable iff (!nrst)
		(!supply_fault_latch_mode && !uv_q && !ov_q && oc_off == '0 &&
			oc_event == '0) |=> stage_enable == $past(output_on);
	endproperty
	a_supply_return: assert property (p_supply_return) else $error("outputs not restored");
	// Age counts cycles since the last change of the reported state
	property p_ec_hold;
		@(posedge core_clk) disable iff (!nrst)
		$changed(ec_state) |-> ec_age >= 32'(EC_FILTER_CYC);
	endproperty
	a_ec_hold: assert property (p_ec_hold) else $error("mirror status toggled too fast");
	property p_ec_code;
		@(posedge core_clk) disable iff (!nrst)
		!(ec_state.above && ec_state.below);
	endproperty
	a_ec_code: assert property (p_ec_code) else $error("mirror unused code shown");

	property p_set_wins;
		@(posedge core_clk) disable iff (!nrst)
		(clr1 && uld_hit[0]) |=> uld_flag[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set lost against clear");

	c_uld_seen: cover property (@(posedge core_clk) disable iff (!nrst) $rose(uld_flag[0]));
	c_oc_retry: cover property (@(posedge core_clk) disable iff (!nrst) $fell(oc_off[0]));
	c_ec_above: cover property (@(posedge core_clk) disable iff (!nrst) $rose(ec_state.above));
	c_latched_ov: cover property (@(posedge core_clk) disable iff (!nrst)
		supply_fault_latch_mode && ov_flag && !ov_q);

endmodule : odsb_output_diag_status_bank

// [odsb_host_model.sv]
// Host model that reaches the status words through the access port.
// Assumes acc_ack comes exactly one edge after the access is taken.

`timescale 1ns/100ps

module odsb_host_model (
	// Clock
	input wire logic core_clk,
	// Access port
	output odsb_pkg::odsb_acc_t acc,
	input wire logic acc_ack,
	input wire logic [15:0] acc_rdata
);
	import odsb_pkg::*;

	initial begin
		acc = '0;
	end

	// ------------------------------------------------------------
	// One access
	// ------------------------------------------------------------
	// Idle fields are inverted so a stale address never looks valid
	task automatic access(input logic [5:0] a, input logic c,
		output logic ok, output logic [15:0] d);
		@(posedge core_clk);
		#1;
		acc = '{valid: 1'b1, clear: c, addr: a};
		@(posedge core_clk);
		#1;
		ok = (acc_ack === 1'b1);
		d = acc_rdata;
		acc = '{valid: 1'b0, clear: ~c, addr: ~a};
	endtask : access
endmodule : odsb_host_model

// [tb_odsb_output_diag_status_bank.sv]
// Self-checking bench for the output diagnostic status bank.
// Assumes short filter and retry units through the bank's parameters.

`timescale 1ns/100ps

module tb_odsb_output_diag_status_bank;
	import odsb_pkg::*;

	localparam int UNIT_CYC = CLK_MHZ;
	logic core_clk;
	logic nrst;
	odsb_acc_t acc;
	logic acc_ack;
	logic [15:0] acc_rdata;
	logic [N_OUT-1:0] output_on;
	logic [N_OUT-1:0] undercurrent_raw;
	logic [N_OUT-1:0] stage_enable;
	logic [N_LAMP-1:0] overcurrent_raw;
	logic [RETRY_W-1:0] overcurrent_retry_delay;
	logic overcurrent_recovery_enable;
	logic supply_fault_latch_mode;
	logic mask_underload_bridge1_high;
	logic mask_underload_bridge1_low;
	logic mask_underload_all_outputs;
	logic electrochromic_mirror_mode;
	logic undervoltage_raw;
	logic overvoltage_raw;
	logic mirror_above_raw;
	logic mirror_below_raw;
	logic global_underload;
	logic global_fault_summary;
	logic mirror_above_target;
	logic mirror_below_target;
	int n_errors = 0;
	int total_checks = 0;
	int k, j, dl, n, r, s, i;

	odsb_output_diag_status_bank #(.ULD_FILTER_US(1), .RETRY_UNIT_US(1))
		i_odsb_output_diag_status_bank (.core_clk, .nrst, .acc, .acc_ack,
		.acc_rdata, .output_on, .overcurrent_recovery_enable,
		.overcurrent_retry_delay, .supply_fault_latch_mode,
		.mask_underload_bridge1_high, .mask_underload_bridge1_low,
		.mask_underload_all_outputs, .electrochromic_mirror_mode,
		.undercurrent_raw, .overcurrent_raw, .undervoltage_raw,
		.overvoltage_raw, .mirror_above_raw, .mirror_below_raw,
		.stage_enable, .global_underload, .global_fault_summary,
		.mirror_above_target, .mirror_below_target);

	odsb_host_model i_odsb_host_model (.core_clk, .acc, .acc_ack,
		.acc_rdata);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] st1_uld(int b);
		return 16'h8000 >> b;
	endfunction : st1_uld

	function automatic logic [15:0] st2_oc(int l);
		return 16'h8000 >> (2 * l);
	endfunction : st2_oc

	task automatic step(int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : step

	task automatic check(input logic [N_OUT-1:0] got,
		input logic [N_OUT-1:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : check

	task automatic rd(input logic [5:0] a, input logic c,
		input logic [15:0] exp, input string m);
		logic ok;
		logic [15:0] d;
		i_odsb_host_model.access(a, c, ok, d);
		check(ok, 1'b1, "ack");
		check(d, exp, m);
	endtask : rd

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Whole sequence needs under 8000 cycles
	initial begin
		#500000;
		n_errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		{output_on, undercurrent_raw, overcurrent_raw} = '0;
		{overcurrent_retry_delay, overcurrent_recovery_enable} = '0;
		{supply_fault_latch_mode, electrochromic_mirror_mode} = '0;
		mask_underload_bridge1_high = 1'b0;
		mask_underload_bridge1_low = 1'b0;
		mask_underload_all_outputs = 1'b0;
		{undervoltage_raw, overvoltage_raw} = '0;
		{mirror_above_raw, mirror_below_raw} = '0;
		void'($urandom(35));
		step(3);
		nrst = 1'b1;
		rd(ADDR_STATUS_1, 1'b0, RST_STATUS, "st1 reset");
		rd(ADDR_STATUS_2, 1'b0, RST_STATUS, "st2 reset");
		rd(6'h3f, 1'b1, READ_UNMAPPED, "unmapped");
		// Underload on HS1, LS1 and one random bridge stage
		for (i = 0; i < 3; i++) begin
			k = (i < 2) ? i : $urandom_range(11, 2);
			undercurrent_raw[k] = 1'b1;
			step(UNIT_CYC + 20);
			rd(ADDR_STATUS_1, 1'b1, 16'h0, "uld while off");
			output_on[k] = 1'b1;
			step(UNIT_CYC - 10);
			undercurrent_raw[k] = 1'b0;
			step(10);
			rd(ADDR_STATUS_1, 1'b0, 16'h0, "short dip");
			undercurrent_raw[k] = 1'b1;
			step(UNIT_CYC + 12);
			rd(ADDR_STATUS_1, 1'b1, st1_uld(k), "uld set");
			check(global_underload, 1'b1, "global uld");
			mask_underload_bridge1_high = (k == 0);
			mask_underload_bridge1_low = (k == 1);
			mask_underload_all_outputs = (k > 1);
			step(3);
			check(global_underload, 1'b0, "masked");
			{mask_underload_bridge1_high, mask_underload_bridge1_low} = '0;
			mask_underload_all_outputs = 1'b0;
			undercurrent_raw[k] = 1'b0;
			step(6);
			rd(ADDR_STATUS_1, 1'b1, st1_uld(k), "sticky");
			rd(ADDR_STATUS_1, 1'b0, 16'h0, "cleared");
			check(global_underload, 1'b0, "global drop");
			output_on[k] = 1'b0;
		end
		// Lamp overcurrent, with then without automatic retry
		for (r = 0; r < 2; r++) begin
			j = $urandom_range(N_LAMP - 1, 0);
			dl = $urandom_range(7, 0);
			overcurrent_recovery_enable = (r == 0);
			overcurrent_retry_delay = dl;
			output_on[12 + j] = 1'b1;
			step(3);
			check(stage_enable[12 + j], 1'b1, "lamp on");
			overcurrent_raw[j] = 1'b1;
			step(8);
			overcurrent_raw[j] = 1'b0;
			check(stage_enable[12 + j], 1'b0, "oc off");
			check(global_fault_summary, 1'b1, "oc summary");
			n = 0;
			while (stage_enable[12 + j] !== 1'b1 && n < 400) begin
				step(1);
				n++;
			end
			if (r == 0) begin
				dl = (dl + 1) * UNIT_CYC;
				check(n >= dl - 8 && n <= dl + 2, 1'b1, "retry");
			end else begin
				check(n == 400, 1'b1, "no retry");
			end
			rd(ADDR_STATUS_2, 1'b1, st2_oc(j), "oc flag");
			output_on[12 + j] = 1'b0;
			step(2);
			output_on[12 + j] = 1'b1;
			step(3);
			check(stage_enable[12 + j], 1'b1, "re-enabled");
			check(global_fault_summary, 1'b0, "summary drop");
			output_on[12 + j] = 1'b0;
		end
		// Undervoltage auto return, overvoltage held for host clear
		output_on = '1;
		for (s = 0; s < 2; s++) begin
			supply_fault_latch_mode = s;
			undervoltage_raw = (s == 0);
			overvoltage_raw = (s == 1);
			step(8);
			check(stage_enable, '0, "supply off");
			{undervoltage_raw, overvoltage_raw} = '0;
			step(8);
			check(stage_enable, s ? '0 : '1, "return");
			rd(ADDR_STATUS_2, 1'b1, s ? 16'h4 : 16'h8, "vs flag");
			step(3);
			check(stage_enable, '1, "after clear");
		end
		output_on = '0;
		// Mirror comparators
		mirror_above_raw = 1'b1;
		step(EC_FILTER_CYC + 20);
		check(mirror_above_target, 1'b0, "mode off");
		electrochromic_mirror_mode = 1'b1;
		step(EC_FILTER_CYC - 80);
		check({mirror_below_target, mirror_above_target}, 2'b00, "early");
		step(100);
		check({mirror_below_target, mirror_above_target}, 2'b01, "above");
		mirror_below_raw = 1'b1;
		step(EC_FILTER_CYC - 80);
		check({mirror_below_target, mirror_above_target}, 2'b01, "held");
		step(100);
		check({mirror_below_target, mirror_above_target}, 2'b00, "both");
		mirror_above_raw = 1'b0;
		step(EC_FILTER_CYC + 20);
		rd(ADDR_STATUS_2, 1'b1, 16'h2, "below");
		rd(ADDR_STATUS_2, 1'b0, 16'h2, "not latched");
		check(global_fault_summary, 1'b0, "mirror summary");
		report_and_stop();
	end
endmodule : tb_odsb_output_diag_status_bank
